// File: common/rtccv_defines.svh
`ifndef RTCCV_DEFINES_SVH
`define RTCCV_DEFINES_SVH

// register addresses on the plain port
`define RTCCV_ADDR_W        2
`define RTCCV_ADDR_CFG      2'h0
`define RTCCV_ADDR_VAL_LO   2'h1
`define RTCCV_ADDR_VAL_HI   2'h2

// config_calibration_reg fields
`define RTCCV_CFG_EN_BIT    15
`define RTCCV_CFG_WREN_BIT  13
`define RTCCV_CFG_HALF_BIT  11
`define RTCCV_CFG_OE_BIT    10
`define RTCCV_CFG_PTR_HI    9
`define RTCCV_CFG_PTR_LO    8
`define RTCCV_CFG_CAL_HI    7
`define RTCCV_CFG_RESET     16'h0000

// timing
`define RTCCV_CLK_HZ        20000000
`define RTCCV_HALF_SEC_MS   500
`define RTCCV_HALF_SEC_CYC  (`RTCCV_CLK_HZ / 1000 * `RTCCV_HALF_SEC_MS)
`define RTCCV_PRESC_W       24

// calendar reset values, bcd
`define RTCCV_SEC_RESET     7'h00
`define RTCCV_MIN_RESET     7'h00
`define RTCCV_HR_RESET      6'h00
`define RTCCV_WDAY_RESET    3'h0
`define RTCCV_DAY_RESET     6'h01
`define RTCCV_MTH_RESET     5'h01
`define RTCCV_YR_RESET      8'h00

// rollover limits, bcd
`define RTCCV_SEC_LAST      7'h59
`define RTCCV_MIN_LAST      7'h59
`define RTCCV_HR_LAST       6'h23
`define RTCCV_WDAY_LAST     3'h6
`define RTCCV_MTH_LAST      5'h12
`define RTCCV_YR_LAST       8'h99

`endif

// File: common/rtccv_pkg.sv
package rtccv_pkg;

	// value_pointer selections
	typedef enum logic [1:0] {
		RTCCV_PTR_MINUTES_SECONDS_WORD = 2'h0,
		RTCCV_PTR_WDHR   = 2'h1,
		RTCCV_PTR_MTHDAY = 2'h2,
		RTCCV_PTR_YEAR   = 2'h3
	} rtccv_ptr_e;

	typedef logic [15:0] rtccv_word_t;

endpackage : rtccv_pkg

// File: common/rtccv_val_if.sv
interface rtccv_val_if;
	logic                 en;
	logic                 wr_lo;
	logic                 wr_hi;
	logic                 half_clr;
	rtccv_pkg::rtccv_ptr_e ptr;
	logic [7:0]           wdata;
	logic                 half;
	rtccv_pkg::rtccv_word_t minutes_seconds_word;
	rtccv_pkg::rtccv_word_t wdhr;
	rtccv_pkg::rtccv_word_t mthday;
	rtccv_pkg::rtccv_word_t year;

	modport ctl  (output en, wr_lo, wr_hi, half_clr, ptr, wdata,
	              input  half, minutes_seconds_word, wdhr, mthday, year);
	modport core (input  en, wr_lo, wr_hi, half_clr, ptr, wdata,
	              output half, minutes_seconds_word, wdhr, mthday, year);
endinterface : rtccv_val_if

// File: src/rtccv_time_core.sv
`include "rtccv_defines.svh"

module rtccv_time_core #(
	parameter int unsigned HALF_SEC_CYC = `RTCCV_HALF_SEC_CYC
) (
	// clock and power-on reset
	input  wire logic clk_sys_in,
	input  wire logic rst_b_in,
	// value access from the control side
	rtccv_val_if.core val_if
);

	localparam logic [`RTCCV_PRESC_W-1:0] HALF_M1 = `RTCCV_PRESC_W'(HALF_SEC_CYC - 1);

	logic [`RTCCV_PRESC_W-1:0] presc_r, presc_nxt;
	logic                      half_r,  half_nxt;
	logic [6:0]                sec_r,   sec_nxt;
	logic [6:0]                min_r,   min_nxt;
	logic [5:0]                hr_r,    hr_nxt;
	logic [2:0]                wday_r,  wday_nxt;
	logic [5:0]                day_r,   day_nxt;
	logic [4:0]                mth_r,   mth_nxt;
	logic [7:0]                yr_r,    yr_nxt;
	logic [7:0]                sec_inc, min_inc, hr_inc, day_inc, mth_inc, yr_inc;
	logic [5:0]                mlen;
	logic                      leap;
	logic                      tick;

	function automatic logic [7:0] bcd_inc(input logic [7:0] v);
		return (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : {v[7:4], v[3:0] + 4'h1};
	endfunction : bcd_inc

	always_comb begin
		presc_nxt = presc_r;
		half_nxt  = half_r;
		sec_nxt   = sec_r;
		min_nxt   = min_r;
		hr_nxt    = hr_r;
		wday_nxt  = wday_r;
		day_nxt   = day_r;
		mth_nxt   = mth_r;
		yr_nxt    = yr_r;
		tick      = 1'b0;
		sec_inc   = bcd_inc({1'b0, sec_r});
		min_inc   = bcd_inc({1'b0, min_r});
		hr_inc    = bcd_inc({2'h0, hr_r});
		day_inc   = bcd_inc({2'h0, day_r});
		mth_inc   = bcd_inc({3'h0, mth_r});
		yr_inc    = bcd_inc(yr_r);
		leap      = yr_r[4] ? (yr_r[3:0] == 4'h2 || yr_r[3:0] == 4'h6) :
		            (yr_r[3:0] == 4'h0 || yr_r[3:0] == 4'h4 || yr_r[3:0] == 4'h8);
		unique case (mth_r)
			5'h02:                      mlen = leap ? 6'h29 : 6'h28;
			5'h04, 5'h06, 5'h09, 5'h11: mlen = 6'h30;
			default:                    mlen = 6'h31;
		endcase
		// counters hold while the clock is disabled
		if (val_if.en) begin
			if (presc_r >= HALF_M1) begin
				presc_nxt = '0;
				half_nxt  = ~half_r;
				tick      = half_r;
			end else begin
				presc_nxt = presc_r + `RTCCV_PRESC_W'(1);
			end
		end
		if (tick) begin
			if (sec_r == `RTCCV_SEC_LAST) begin
				sec_nxt = '0;
				if (min_r == `RTCCV_MIN_LAST) begin
					min_nxt = '0;
					if (hr_r == `RTCCV_HR_LAST) begin
						hr_nxt   = '0;
						wday_nxt = (wday_r == `RTCCV_WDAY_LAST) ? 3'h0 : wday_r + 3'h1;
						if (day_r >= mlen) begin
							day_nxt = `RTCCV_DAY_RESET;
							if (mth_r == `RTCCV_MTH_LAST) begin
								mth_nxt = `RTCCV_MTH_RESET;
								yr_nxt  = (yr_r == `RTCCV_YR_LAST) ? 8'h00 : yr_inc;
							end else begin
								mth_nxt = mth_inc[4:0];
							end
						end else begin
							day_nxt = day_inc[5:0];
						end
					end else begin
						hr_nxt = hr_inc[5:0];
					end
				end else begin
					min_nxt = min_inc[6:0];
				end
			end else begin
				sec_nxt = sec_inc[6:0];
			end
		end
		// restart the second so software sets seconds on a clean boundary
		if (val_if.half_clr) begin
			presc_nxt = '0;
			half_nxt  = 1'b0;
		end
		// software writes win over the running count
		if (val_if.wr_lo) begin
			unique case (val_if.ptr)
				rtccv_pkg::RTCCV_PTR_MINUTES_SECONDS_WORD: sec_nxt = val_if.wdata[6:0];
				rtccv_pkg::RTCCV_PTR_WDHR:   hr_nxt  = val_if.wdata[5:0];
				rtccv_pkg::RTCCV_PTR_MTHDAY: day_nxt = val_if.wdata[5:0];
				rtccv_pkg::RTCCV_PTR_YEAR:   yr_nxt  = val_if.wdata;
			endcase
		end
		if (val_if.wr_hi) begin
			unique case (val_if.ptr)
				rtccv_pkg::RTCCV_PTR_MINUTES_SECONDS_WORD: min_nxt  = val_if.wdata[6:0];
				rtccv_pkg::RTCCV_PTR_WDHR:   wday_nxt = val_if.wdata[2:0];
				rtccv_pkg::RTCCV_PTR_MTHDAY: mth_nxt  = val_if.wdata[4:0];
				// no upper year byte; a same-cycle rollover must not be lost
				rtccv_pkg::RTCCV_PTR_YEAR:   begin end
			endcase
		end
	end

	always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			presc_r <= '0;
			half_r  <= 1'b0;
			sec_r   <= `RTCCV_SEC_RESET;
			min_r   <= `RTCCV_MIN_RESET;
			hr_r    <= `RTCCV_HR_RESET;
			wday_r  <= `RTCCV_WDAY_RESET;
			day_r   <= `RTCCV_DAY_RESET;
			mth_r   <= `RTCCV_MTH_RESET;
			yr_r    <= `RTCCV_YR_RESET;
		end else begin
			presc_r <= presc_nxt;
			half_r  <= half_nxt;
			sec_r   <= sec_nxt;
			min_r   <= min_nxt;
			hr_r    <= hr_nxt;
			wday_r  <= wday_nxt;
			day_r   <= day_nxt;
			mth_r   <= mth_nxt;
			yr_r    <= yr_nxt;
		end
	end

	assign val_if.half   = half_r;
	assign val_if.minutes_seconds_word = {1'b0, min_r, 1'b0, sec_r};
	assign val_if.wdhr   = {5'h00, wday_r, 2'h0, hr_r};
	assign val_if.mthday = {3'h0, mth_r, 2'h0, day_r};
	assign val_if.year   = {8'h00, yr_r};

endmodule : rtccv_time_core

// File: src/rtccv_top.sv
// What this block does
// - value words take software writes while the write unlock bit is set.
// - with the unlock bit clear, value word writes are dropped, contents kept.
// - clock enable bit changes only while the write unlock bit is one.
// - config register clears only on power-on reset, never on soft reset.
// - half-second flag is read-only, high in second half, cleared by seconds write.
// - year word bits 7..4 hold the year tens digit in bcd.
// - year word bits 3..0 hold year ones digit; upper byte reads zero.
// - year word takes writes only while the unlock bit is one.
// - pointer value 10 shows month in high byte, day in low byte.
`include "rtccv_defines.svh"

module rtccv_top #(
	parameter int unsigned HALF_SEC_CYC = `RTCCV_HALF_SEC_CYC
) (
	// clock and resets
	input  wire logic                     clk_sys_in,
	input  wire logic                     rst_b_in,
	input  wire logic                     soft_rst_in,
	// register port
	input  wire logic [`RTCCV_ADDR_W-1:0] reg_addr_in,
	input  wire logic [15:0]              reg_wdata_in,
	input  wire logic                     reg_wr_in,
	input  wire logic                     reg_rd_in,
	output logic      [15:0]              reg_rdata_out,
	// status to the surrounding chip
	output logic                          clock_enable_out,
	output logic                          clock_output_enable_out
);

	rtccv_val_if val_if ();

	logic                  clock_enable_bit_r,   clock_enable_bit_nxt;
	logic                  value_write_unlock_r, value_write_unlock_nxt;
	logic                  clock_output_enable_r, clock_output_enable_nxt;
	rtccv_pkg::rtccv_ptr_e value_pointer_r,      value_pointer_nxt;
	logic [7:0]            cal_r,                cal_nxt;
	logic [15:0]           rdata_r,              rdata_nxt;
	logic                  cfg_wr;
	logic                  hi_acc;
	logic [15:0]           window;
	logic [15:0]           cfg_view;

	rtccv_time_core #(
		.HALF_SEC_CYC (HALF_SEC_CYC)
	) u_core (
		.clk_sys_in (clk_sys_in),
		.rst_b_in   (rst_b_in),
		.val_if     (val_if.core)
	);

	always_comb begin
		cfg_wr = reg_wr_in && (reg_addr_in == `RTCCV_ADDR_CFG);
		hi_acc = (reg_wr_in || reg_rd_in) && (reg_addr_in == `RTCCV_ADDR_VAL_HI);
		unique case (value_pointer_r)
			rtccv_pkg::RTCCV_PTR_MINUTES_SECONDS_WORD: window = val_if.minutes_seconds_word;
			rtccv_pkg::RTCCV_PTR_WDHR:   window = val_if.wdhr;
			rtccv_pkg::RTCCV_PTR_MTHDAY: window = val_if.mthday;
			rtccv_pkg::RTCCV_PTR_YEAR:   window = val_if.year;
		endcase
		// sync flag not modelled, reads zero
		cfg_view = {clock_enable_bit_r, 1'b0, value_write_unlock_r, 1'b0,
		            val_if.half, clock_output_enable_r, value_pointer_r, cal_r};

		clock_enable_bit_nxt    = clock_enable_bit_r;
		value_write_unlock_nxt  = value_write_unlock_r;
		clock_output_enable_nxt = clock_output_enable_r;
		value_pointer_nxt       = value_pointer_r;
		cal_nxt                 = cal_r;
		if (cfg_wr) begin
			value_write_unlock_nxt  = reg_wdata_in[`RTCCV_CFG_WREN_BIT];
			clock_output_enable_nxt = reg_wdata_in[`RTCCV_CFG_OE_BIT];
			value_pointer_nxt       = rtccv_pkg::rtccv_ptr_e'(
				reg_wdata_in[`RTCCV_CFG_PTR_HI:`RTCCV_CFG_PTR_LO]);
			cal_nxt                 = reg_wdata_in[`RTCCV_CFG_CAL_HI:0];
			// lock state before this write decides
			if (value_write_unlock_r) begin
				clock_enable_bit_nxt = reg_wdata_in[`RTCCV_CFG_EN_BIT];
			end
		end
		// pointer walks down and parks at the seconds word
		if (hi_acc && value_pointer_r != rtccv_pkg::RTCCV_PTR_MINUTES_SECONDS_WORD) begin
			value_pointer_nxt = rtccv_pkg::rtccv_ptr_e'(value_pointer_r - 2'h1);
		end

		// read data stand for one cycle only
		rdata_nxt = 16'h0000;
		if (reg_rd_in) begin
			unique case (reg_addr_in)
				`RTCCV_ADDR_CFG:    rdata_nxt = cfg_view;
				`RTCCV_ADDR_VAL_LO: rdata_nxt = {8'h00, window[7:0]};
				`RTCCV_ADDR_VAL_HI: rdata_nxt = {8'h00, window[15:8]};
				default:            rdata_nxt = 16'h0000;
			endcase
		end
		if (soft_rst_in) begin
			rdata_nxt = 16'h0000;
		end
	end

	// value access to the core; value writes gated by the lock, half clear is not
	assign val_if.en       = clock_enable_bit_r;
	assign val_if.ptr      = value_pointer_r;
	assign val_if.wdata    = reg_wdata_in[7:0];
	assign val_if.wr_lo    = reg_wr_in && (reg_addr_in == `RTCCV_ADDR_VAL_LO)
	                         && value_write_unlock_r;
	assign val_if.wr_hi    = reg_wr_in && (reg_addr_in == `RTCCV_ADDR_VAL_HI)
	                         && value_write_unlock_r;
	assign val_if.half_clr = reg_wr_in && (reg_addr_in == `RTCCV_ADDR_VAL_LO)
	                         && (value_pointer_r == rtccv_pkg::RTCCV_PTR_MINUTES_SECONDS_WORD);

	// soft reset deliberately absent: settings survive everything but power-on
	always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			clock_enable_bit_r    <= 1'(`RTCCV_CFG_RESET >> `RTCCV_CFG_EN_BIT);
			value_write_unlock_r  <= 1'b0;
			clock_output_enable_r <= 1'b0;
			value_pointer_r       <= rtccv_pkg::RTCCV_PTR_MINUTES_SECONDS_WORD;
			cal_r                 <= 8'h00;
			rdata_r               <= 16'h0000;
		end else begin
			clock_enable_bit_r    <= clock_enable_bit_nxt;
			value_write_unlock_r  <= value_write_unlock_nxt;
			clock_output_enable_r <= clock_output_enable_nxt;
			value_pointer_r       <= value_pointer_nxt;
			cal_r                 <= cal_nxt;
			rdata_r               <= rdata_nxt;
		end
	end

	assign reg_rdata_out           = rdata_r;
	assign clock_enable_out        = clock_enable_bit_r;
	assign clock_output_enable_out = clock_output_enable_r;

endmodule : rtccv_top

// File: dv/rtccv_chk.sv
`include "rtccv_defines.svh"

module rtccv_chk #(
	parameter int unsigned HALF_SEC_CYC = 8
) (
	// clock and resets
	input wire logic                     clk_sys_in,
	input wire logic                     rst_b_in,
	input wire logic                     soft_rst_in,
	// register port
	input wire logic [`RTCCV_ADDR_W-1:0] reg_addr_in,
	input wire logic [15:0]              reg_wdata_in,
	input wire logic                     reg_wr_in,
	input wire logic                     reg_rd_in,
	input wire logic [15:0]              reg_rdata_out,
	// status
	input wire logic                     clock_enable_out,
	input wire logic                     clock_output_enable_out
);
	timeunit 1ns;
	timeprecision 1ns;
	logic       unlock_r, unlock_nxt;
	logic [1:0] ptr_r, ptr_nxt;
	logic [7:0] cal_r, cal_nxt;
	logic       cfg_wr, hi_acc, wd15;
	assign cfg_wr = reg_wr_in && reg_addr_in == 2'h0;
	assign hi_acc = (reg_wr_in || reg_rd_in) && reg_addr_in == 2'h2;
	assign wd15 = reg_wdata_in[15];
	// shadow of software-visible config state
	always_comb begin
		unlock_nxt = unlock_r;
		ptr_nxt = ptr_r;
		cal_nxt = cal_r;
		if (cfg_wr) begin
			unlock_nxt = reg_wdata_in[13];
			ptr_nxt = reg_wdata_in[9:8];
			cal_nxt = reg_wdata_in[7:0];
		end else if (hi_acc && ptr_r != 2'h0) begin
			ptr_nxt = ptr_r - 2'h1;
		end
	end
	always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			unlock_r <= 1'b0;
			ptr_r <= 2'h0;
			cal_r <= 8'h00;
		end else begin
			unlock_r <= unlock_nxt;
			ptr_r <= ptr_nxt;
			cal_r <= cal_nxt;
		end
	end
	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (!rst_b_in);
	a_rdata_idle: assert property (!$past(reg_rd_in) |-> reg_rdata_out == 16'h0000)
		else $error("read data not zero outside read slot");
	a_unmapped_rd: assert property (reg_rd_in && reg_addr_in == 2'h3 |=> reg_rdata_out == 16'h0000)
		else $error("unmapped read not zero");
	a_byte_upper: assert property (reg_rd_in && reg_addr_in inside {2'h1, 2'h2}
		|=> reg_rdata_out[15:8] == 8'h00) else $error("value byte upper half not zero");
	a_en_locked: assert property (cfg_wr && !unlock_r |=> $stable(clock_enable_out))
		else $error("enable changed while locked");
	a_en_unlocked: assert property (cfg_wr && unlock_r |=> clock_enable_out == $past(wd15))
		else $error("enable not taken while unlocked");
	a_en_hold: assert property (!cfg_wr |=> $stable(clock_enable_out))
		else $error("enable changed without config write");
	a_cfg_fields: assert property (reg_rd_in && reg_addr_in == 2'h0 && !soft_rst_in
		|=> reg_rdata_out[15] == clock_enable_out && reg_rdata_out[14] == 1'b0
		&& reg_rdata_out[13] == $past(unlock_r) && reg_rdata_out[10] == clock_output_enable_out)
		else $error("config read fields wrong");
	a_ptr_track: assert property (reg_rd_in && reg_addr_in == 2'h0 && !soft_rst_in
		|=> reg_rdata_out[9:8] == $past(ptr_r) && reg_rdata_out[7:0] == $past(cal_r))
		else $error("pointer or calibration readback wrong");
	a_half_clear: assert property (reg_wr_in && reg_addr_in == 2'h1 && ptr_r == 2'h0
		##[1:3] reg_rd_in && reg_addr_in == 2'h0 && !soft_rst_in |=> !reg_rdata_out[11])
		else $error("half flag not cleared by seconds write");
	c_unlock_wr: cover property (cfg_wr && unlock_r);
	c_year_hi: cover property (reg_rd_in && reg_addr_in == 2'h2 && ptr_r == 2'h3);
	c_half_set: cover property (reg_rd_in && reg_addr_in == 2'h0 ##1 reg_rdata_out[11]);
endmodule : rtccv_chk

bind rtccv_top rtccv_chk #(.HALF_SEC_CYC(HALF_SEC_CYC)) u_rtccv_chk (
	.clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in), .soft_rst_in(soft_rst_in),
	.reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
	.reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
	.clock_enable_out(clock_enable_out), .clock_output_enable_out(clock_output_enable_out)
);

// File: dv/tb_top.sv
`define CHK(n, e, g) check_val(n, e, g)

module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk_sys_in = 1'b0, rst_b_in = 1'b0, soft_rst_in = 1'b0;
	logic [1:0]  reg_addr_in = 2'h0;
	logic [15:0] reg_wdata_in = 16'h0000, reg_rdata_out, d;
	logic        reg_wr_in = 1'b0, reg_rd_in = 1'b0, clock_enable_out, oe;
	logic        seen1;
	int          error_cnt = 0, checks_done = 0, cyc = 0;
	// short half second keeps the run brief
	rtccv_top #(.HALF_SEC_CYC(8)) u_rtccv_top (
		.clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in), .soft_rst_in(soft_rst_in),
		.reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
		.reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
		.clock_enable_out(clock_enable_out), .clock_output_enable_out(oe)
	);
	always #25 clk_sys_in = ~clk_sys_in;
	task automatic check_val(input string n, input logic [15:0] e, input logic [15:0] g);
		checks_done++;
		if (g !== e) begin
			error_cnt++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask : check_val
	task automatic wr(input logic [1:0] a, input logic [15:0] v);
		@(posedge clk_sys_in);
		reg_addr_in <= a;
		reg_wdata_in <= v;
		reg_wr_in <= 1'b1;
		@(posedge clk_sys_in);
		reg_wr_in <= 1'b0;
		// let the registers settle before a caller looks at outputs
		#1;
	endtask : wr
	task automatic rd(input logic [1:0] a, output logic [15:0] v);
		@(posedge clk_sys_in);
		reg_addr_in <= a;
		reg_rd_in <= 1'b1;
		@(posedge clk_sys_in);
		reg_rd_in <= 1'b0;
		#1 v = reg_rdata_out;
	endtask : rd
	task automatic chk_rd(input string n, input logic [1:0] a, input logic [15:0] e);
		logic [15:0] v;
		rd(a, v);
		`CHK(n, e, v);
	endtask : chk_rd
	task automatic t_reset;
		chk_rd("cfg after reset", 2'h0, 16'h0000);
		chk_rd("unmapped", 2'h3, 16'h0000);
	endtask : t_reset
	task automatic t_locked;
		wr(2'h0, 16'h8000);
		`CHK("enable locked", 16'h0000, {15'h0, clock_enable_out});
		wr(2'h1, 16'h0045);
		chk_rd("sec locked", 2'h1, 16'h0000);
		wr(2'h2, 16'h0012);
		chk_rd("min locked", 2'h2, 16'h0000);
	endtask : t_locked
	task automatic t_year;
		wr(2'h0, 16'h2300);
		wr(2'h1, 16'h0025);
		chk_rd("year digits", 2'h1, 16'h0025);
		chk_rd("year upper", 2'h2, 16'h0000);
		wr(2'h1, 16'h0031);
		chk_rd("day", 2'h1, 16'h0031);
		chk_rd("month", 2'h2, 16'h0001);
		chk_rd("ptr 01", 2'h0, 16'h2100);
		chk_rd("weekday", 2'h2, 16'h0000);
		chk_rd("hi at ptr 00", 2'h2, 16'h0000);
		chk_rd("ptr stays 00", 2'h0, 16'h2000);
	endtask : t_year
	task automatic t_lock_year;
		wr(2'h0, 16'h075a);
		wr(2'h1, 16'h0099);
		chk_rd("year locked", 2'h1, 16'h0025);
		@(posedge clk_sys_in);
		soft_rst_in <= 1'b1;
		@(posedge clk_sys_in);
		soft_rst_in <= 1'b0;
		chk_rd("cfg kept", 2'h0, 16'h075a);
		`CHK("oe kept", 16'h0001, {15'h0, oe});
	endtask : t_lock_year
	task automatic t_half;
		wr(2'h0, 16'h2000);
		wr(2'h0, 16'ha000);
		`CHK("enable set", 16'h0001, {15'h0, clock_enable_out});
		wr(2'h1, 16'h0000);
		seen1 = 1'b0;
		repeat (20) begin
			rd(2'h0, d);
			if (d[11] === 1'b1) seen1 = 1'b1;
		end
		`CHK("half seen", 16'h0001, {15'h0, seen1});
		rd(2'h1, d);
		`CHK("sec advanced", 16'h0001, {15'h0, d != 16'h0000});
		wr(2'h0, 16'h2000);
		rd(2'h1, d);
		repeat (40) @(posedge clk_sys_in);
		chk_rd("sec held", 2'h1, d);
		wr(2'h1, 16'h0000);
		wr(2'h0, 16'h2800);
		chk_rd("half read only", 2'h0, 16'h2000);
	endtask : t_half
	task automatic test_done;
		$display("checks %0d errors %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : test_done
	// ceiling well above the roughly 150 cycles the scenarios need
	always @(posedge clk_sys_in) begin
		cyc++;
		if (cyc == 5000) begin
			error_cnt++;
			test_done();
		end
	end
	initial begin
		repeat (6) @(posedge clk_sys_in);
		rst_b_in <= 1'b1;
		t_reset();
		t_locked();
		t_year();
		t_lock_year();
		t_half();
		test_done();
	end
endmodule : tb_top
